// >>> design/bpfs_top.sv
/*
 Secondary-bus pin-function select: straps, request/grant swap, general
 pins, secondary reset and test port, with an AXI4-Lite register slave.
 Assumes all pins are synchronous to clk_in; pad inversion lies outside.
*/
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
module bpfs_top (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic [bpfs_pkg::BPFS_ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [bpfs_pkg::BPFS_ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic external_arbiter_strap_in,
	input wire logic clock_run_strap_in,
	input wire logic [bpfs_pkg::BPFS_NREQ-1:0] req_pins_in,
	output logic [bpfs_pkg::BPFS_NREQ-1:0] grant_pins_out,
	output logic [bpfs_pkg::BPFS_NREQ-1:0] arb_req_out,
	input wire logic [bpfs_pkg::BPFS_NREQ-1:0] arb_gnt_in,
	input wire logic bridge_req_in,
	output logic bridge_gnt_out,
	output logic external_arbiter_out,
	output logic clock_run_enable_out,
	output logic clock_run_in_out,
	input wire logic [bpfs_pkg::BPFS_NPIN-1:0] general_pin_in,
	output logic [bpfs_pkg::BPFS_NPIN-1:0] general_pin_out,
	output logic [bpfs_pkg::BPFS_NPIN-1:0] general_pin_oe_out,
	output logic [bpfs_pkg::BPFS_NPIN-1:0] general_pin_pullup_out,
	output logic power_override_output_out,
	output logic secondary_bus_reset_n_out,
	input wire logic test_clock_in,
	input wire logic test_mode_in,
	input wire logic test_data_in,
	input wire logic test_reset_n_in,
	output logic test_data_out
);
	import bpfs_pkg::*;
	// ----------------------------------------
	// Straps, caught while reset is held
	// ----------------------------------------
	logic ext_q, ext_d, crun_q, crun_d;
	always_comb
	begin
		ext_d = srst_in ? external_arbiter_strap_in : ext_q;
		crun_d = srst_in ? clock_run_strap_in : crun_q;
	end
	always_ff @(posedge clk_in)
	begin
		if (srst_in || ce_in)
		begin
			ext_q <= ext_d;
			crun_q <= crun_d;
		end
	end
	assign external_arbiter_out = ext_q;
	assign clock_run_enable_out = crun_q;
	// ----------------------------------------
	// Register slave
	// ----------------------------------------
	logic [2:0] dir_q, dir_d, dout_q, dout_d;
	logic [31:0] gctl_q, gctl_d, rdata_q, rdata_d;
	logic [BPFS_ADDR_W-1:0] awa_q, awa_d;
	logic [31:0] wd_q, wd_d;
	logic [3:0] ws_q, ws_d;
	logic awg_q, awg_d, wg_q, wg_d, awr_q, awr_d, wr_q, wr_d;
	logic bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [2:0] pin_in_q;
	always_comb
	begin
		awa_d = awa_q;
		wd_d = wd_q;
		ws_d = ws_q;
		awg_d = awg_q;
		wg_d = wg_q;
		bv_d = bv_q;
		bresp_d = bresp_q;
		rv_d = rv_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		dir_d = dir_q;
		dout_d = dout_q;
		gctl_d = gctl_q;
		if (s_axi_awvalid_in && awr_q)
		begin
			awa_d = s_axi_awaddr_in;
			awg_d = 1'b1;
		end
		if (s_axi_wvalid_in && wr_q)
		begin
			wd_d = s_axi_wdata_in;
			ws_d = s_axi_wstrb_in;
			wg_d = 1'b1;
		end
		if (bv_q && s_axi_bready_in)
		begin
			bv_d = 1'b0;
		end
		if (awg_q && wg_q && !bv_q)
		begin
			awg_d = 1'b0;
			wg_d = 1'b0;
			bv_d = 1'b1;
			bresp_d = BPFS_RESP_OKAY;
			case (awa_q)
				BPFS_OFS_DIR: dir_d = 3'(bpfs_merge({29'h0, dir_q}, wd_q, ws_q));
				BPFS_OFS_DOUT: dout_d = 3'(bpfs_merge({29'h0, dout_q}, wd_q, ws_q));
				BPFS_OFS_GCTL: gctl_d = bpfs_merge(gctl_q, wd_q, ws_q);
				BPFS_OFS_DIN, BPFS_OFS_STAT: bresp_d = BPFS_RESP_OKAY;
				default: bresp_d = BPFS_RESP_SLVERR;
			endcase
		end
		if (rv_q && s_axi_rready_in)
		begin
			rv_d = 1'b0;
		end
		if (s_axi_arvalid_in && arr_q)
		begin
			rv_d = 1'b1;
			rresp_d = BPFS_RESP_OKAY;
			case (s_axi_araddr_in)
				BPFS_OFS_DIR: rdata_d = {29'h0, dir_q};
				BPFS_OFS_DOUT: rdata_d = {29'h0, dout_q};
				BPFS_OFS_DIN: rdata_d = {29'h0, pin_in_q};
				BPFS_OFS_GCTL: rdata_d = gctl_q;
				BPFS_OFS_STAT: rdata_d = {29'h0, clock_run_in_out, crun_q, ext_q};
				default:
				begin
					rdata_d = 32'h0000_0000;
					rresp_d = BPFS_RESP_SLVERR;
				end
			endcase
		end
		// One write and one read in flight; ready drops while held
		awr_d = !awg_d && !bv_d;
		wr_d = !wg_d && !bv_d;
		arr_d = !rv_d;
	end
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			awa_q <= '0;
			wd_q <= 32'h0000_0000;
			ws_q <= 4'h0;
			awg_q <= 1'b0;
			wg_q <= 1'b0;
			awr_q <= 1'b0;
			wr_q <= 1'b0;
			bv_q <= 1'b0;
			bresp_q <= BPFS_RESP_OKAY;
			arr_q <= 1'b0;
			rv_q <= 1'b0;
			rresp_q <= BPFS_RESP_OKAY;
			rdata_q <= 32'h0000_0000;
			dir_q <= BPFS_PIN_RST;
			dout_q <= BPFS_PIN_RST;
			gctl_q <= BPFS_GCTL_RST;
			pin_in_q <= BPFS_PIN_RST;
		end
		else if (ce_in)
		begin
			awa_q <= awa_d;
			wd_q <= wd_d;
			ws_q <= ws_d;
			awg_q <= awg_d;
			wg_q <= wg_d;
			awr_q <= awr_d;
			wr_q <= wr_d;
			bv_q <= bv_d;
			bresp_q <= bresp_d;
			arr_q <= arr_d;
			rv_q <= rv_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			dir_q <= dir_d;
			dout_q <= dout_d;
			gctl_q <= gctl_d;
			pin_in_q <= general_pin_in;
		end
	end
	assign s_axi_awready_out = awr_q;
	assign s_axi_wready_out = wr_q;
	assign s_axi_bvalid_out = bv_q;
	assign s_axi_bresp_out = bresp_q;
	assign s_axi_arready_out = arr_q;
	assign s_axi_rvalid_out = rv_q;
	assign s_axi_rresp_out = rresp_q;
	assign s_axi_rdata_out = rdata_q;
	// ----------------------------------------
	// Request/grant swap, clock run, secondary reset
	// ----------------------------------------
	logic [BPFS_NREQ-1:0] areq_q, areq_d, gnt_q, gnt_d;
	logic bgnt_q, bgnt_d, crin_q, crin_d, secondary_bus_reset_out_n_q, secondary_bus_reset_out_n_d, pwr_q, pwr_d;
	always_comb
	begin
		if (ext_q)
		begin
			// Internal arbiter gets requests 1 to 5, its grants unused; pin zero pair belongs to the bridge
			areq_d = {req_pins_in[BPFS_NREQ-1:1], 1'b0};
			bgnt_d = req_pins_in[0];
			gnt_d = {{(BPFS_NREQ-1){1'b0}}, bridge_req_in};
		end
		else
		begin
			areq_d = req_pins_in;
			bgnt_d = 1'b0;
			gnt_d = arb_gnt_in;
		end
		crin_d = crun_q && general_pin_in[0];
		secondary_bus_reset_out_n_d = !gctl_q[BPFS_SECRST_BIT];
		pwr_d = bpfs_pwr_on(gctl_q);
	end
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			areq_q <= '0;
			gnt_q <= '0;
			bgnt_q <= 1'b0;
			crin_q <= 1'b0;
			secondary_bus_reset_out_n_q <= 1'b0;
			pwr_q <= 1'b0;
		end
		else if (ce_in)
		begin
			areq_q <= areq_d;
			gnt_q <= gnt_d;
			bgnt_q <= bgnt_d;
			crin_q <= crin_d;
			secondary_bus_reset_out_n_q <= secondary_bus_reset_out_n_d;
			pwr_q <= pwr_d;
		end
	end
	assign arb_req_out = areq_q;
	assign grant_pins_out = gnt_q;
	assign bridge_gnt_out = bgnt_q;
	assign clock_run_in_out = crin_q;
	assign secondary_bus_reset_n_out = secondary_bus_reset_out_n_q;
	// Same flop timing as pin one's output stage, which drives high under override
	assign power_override_output_out = pwr_q;
	// ----------------------------------------
	// Pin muxes and test port
	// ----------------------------------------
	bpfs_gpio u_gpio (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.dir_in(dir_q),
		.dout_in(dout_q),
		.clock_run_mode_in(crun_q),
		.power_override_select_in(pwr_d),
		.pin_out(general_pin_out),
		.pin_oe_out(general_pin_oe_out),
		.pullup_en_out(general_pin_pullup_out)
	);
	bpfs_tap u_tap (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.tck_in(test_clock_in),
		.tms_in(test_mode_in),
		.tdi_in(test_data_in),
		.trst_n_in(test_reset_n_in),
		.scan_in({3'h0, pin_in_q, crun_q, ext_q}),
		.tdo_out(test_data_out)
	);
	AST_STRAP_EXT: assert property (@(posedge clk_in)
		srst_in |=> external_arbiter_out == $past(external_arbiter_strap_in))
		else $error("arbiter strap not caught");
	AST_STRAP_CRUN: assert property (@(posedge clk_in)
		srst_in ##1 !srst_in [*3] |-> clock_run_enable_out == $past(clock_run_enable_out, 2))
		else $error("clock-run strap changed after reset");
	AST_INT_REQ: assert property (@(posedge clk_in) disable iff (srst_in)
		ce_in && !ext_q |=> arb_req_out == $past(req_pins_in) && !bridge_gnt_out)
		else $error("requests not passed to arbiter");
	AST_EXT_GNT: assert property (@(posedge clk_in) disable iff (srst_in)
		ce_in && ext_q |=> bridge_gnt_out == $past(req_pins_in[0]) && !arb_req_out[0])
		else $error("request pin zero not taken as grant");
	AST_EXT_REQ: assert property (@(posedge clk_in) disable iff (srst_in)
		ce_in && ext_q |=> grant_pins_out[0] == $past(bridge_req_in))
		else $error("bridge request not on grant pin zero");
	AST_SEC_RST: assert property (@(posedge clk_in)
		srst_in |=> !secondary_bus_reset_n_out)
		else $error("secondary reset released during reset");
	AST_BRESP: assert property (@(posedge clk_in) disable iff (srst_in)
		ce_in && awg_q && wg_q && !bv_q |=> s_axi_bvalid_out)
		else $error("write response missing");
	COV_EXT: cover property (@(posedge clk_in) ext_q && bridge_gnt_out);
	COV_CRUN: cover property (@(posedge clk_in) crun_q && clock_run_in_out);
endmodule

// >>> design/bpfs_pkg.sv
/*
 Constants, state type and helpers for the bridge pin-function select block.
 Assumes a single 125 MHz clock and an AXI4-Lite master with 32-bit data.
*/
// Summary of operation
// - Arbiter strap 0 internal, 1 external
// - Internal arbiter: six request pins are inputs
// - External arbiter: request pin zero is grant
// - External arbiter: grant pin zero carries request
// - Clock-run strap 0 disables, 1 enables
// - Pin zero is clock-run input in clock-run mode
// - Pin two is only general purpose
// - Pullup only in reset or input mode
// - Dedicated secondary bus reset output
// - Test reset initialises controller without test clock
// - Controller advances on test clock, decodes mode
// - Shift in on data input, out on output
package bpfs_pkg;
	localparam int unsigned BPFS_ADDR_W = 8;
	localparam int unsigned BPFS_NPIN = 3;
	localparam int unsigned BPFS_NREQ = 6;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] BPFS_OFS_DIR = 8'h00;
	localparam logic [7:0] BPFS_OFS_DOUT = 8'h04;
	localparam logic [7:0] BPFS_OFS_DIN = 8'h08;
	localparam logic [7:0] BPFS_OFS_GCTL = 8'h0c;
	localparam logic [7:0] BPFS_OFS_STAT = 8'h10;
	localparam int unsigned BPFS_PWR_LSB = 20;
	localparam int unsigned BPFS_PWR_MSB = 22;
	localparam logic [2:0] BPFS_PWR_SEL_A = 3'h1;
	localparam logic [2:0] BPFS_PWR_SEL_B = 3'h3;
	localparam int unsigned BPFS_SECRST_BIT = 0;
	localparam logic [31:0] BPFS_GCTL_RST = 32'h0000_0000;
	localparam logic [2:0] BPFS_PIN_RST = 3'h0;
	localparam logic [1:0] BPFS_RESP_OKAY = 2'h0;
	localparam logic [1:0] BPFS_RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// Test access port
	// ----------------------------------------
	localparam int unsigned BPFS_IR_W = 2;
	localparam logic [1:0] BPFS_IR_BYPASS = 2'h3;
	localparam logic [1:0] BPFS_IR_SCAN = 2'h1;
	localparam int unsigned BPFS_SCAN_W = 8;
	typedef enum logic [3:0] {
		BPFS_TLR = 4'h0, BPFS_IDLE = 4'h1, BPFS_SEL_DR = 4'h2, BPFS_CAP_DR = 4'h3,
		BPFS_SH_DR = 4'h4, BPFS_EX1_DR = 4'h5, BPFS_PA_DR = 4'h6, BPFS_EX2_DR = 4'h7,
		BPFS_UPD_DR = 4'h8, BPFS_SEL_IR = 4'h9, BPFS_CAP_IR = 4'ha, BPFS_SH_IR = 4'hb,
		BPFS_EX1_IR = 4'hc, BPFS_PA_IR = 4'hd, BPFS_EX2_IR = 4'he, BPFS_UPD_IR = 4'hf
	} bpfs_tap_e;
	function automatic logic [31:0] bpfs_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction
	function automatic logic bpfs_pwr_on(input logic [31:0] gctl);
		return (gctl[BPFS_PWR_MSB:BPFS_PWR_LSB] == BPFS_PWR_SEL_A) ||
			(gctl[BPFS_PWR_MSB:BPFS_PWR_LSB] == BPFS_PWR_SEL_B);
	endfunction
endpackage

// >>> design/bpfs_gpio.sv
/*
 Three general-purpose pin muxes with their pullup gating.
 Assumes direction and output data come from registers in the top.
*/
`timescale 1ns/10ps
module bpfs_gpio (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic [2:0] dir_in,
	input wire logic [2:0] dout_in,
	input wire logic clock_run_mode_in,
	input wire logic power_override_select_in,
	output logic [2:0] pin_out,
	output logic [2:0] pin_oe_out,
	output logic [2:0] pullup_en_out
);
	import bpfs_pkg::*;
	logic [2:0] out_q, out_d, oe_q, oe_d, pull_q, pull_d;
	always_comb
	begin
		oe_d = dir_in;
		out_d = dout_in;
		if (clock_run_mode_in)
		begin
			oe_d[0] = 1'b0;
		end
		if (power_override_select_in)
		begin
			oe_d[1] = 1'b1;
			out_d[1] = 1'b1;
		end
		pull_d = ~oe_d;
	end
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			out_q <= BPFS_PIN_RST;
			oe_q <= BPFS_PIN_RST;
			pull_q <= ~BPFS_PIN_RST;
		end
		else if (ce_in)
		begin
			out_q <= out_d;
			oe_q <= oe_d;
			pull_q <= pull_d;
		end
	end
	assign pin_out = out_q;
	assign pin_oe_out = oe_q;
	assign pullup_en_out = pull_q;
	AST_PIN0_CLKRUN: assert property (@(posedge clk_in) disable iff (srst_in)
		ce_in && clock_run_mode_in |=> !pin_oe_out[0])
		else $error("pin zero driven in clock-run mode");
	AST_PIN1_GP: assert property (@(posedge clk_in) disable iff (srst_in)
		ce_in && !power_override_select_in |=> pin_oe_out[1] == $past(dir_in[1]))
		else $error("pin one ignores its direction bit");
	AST_PIN1_PWR: assert property (@(posedge clk_in) disable iff (srst_in)
		ce_in && power_override_select_in |=> pin_oe_out[1] && pin_out[1])
		else $error("power override not driven");
	AST_PIN2_GP: assert property (@(posedge clk_in) disable iff (srst_in)
		ce_in |=> pin_oe_out[2] == $past(dir_in[2]) && pin_out[2] == $past(dout_in[2]))
		else $error("pin two not plain general purpose");
	AST_PULLUP: assert property (@(posedge clk_in)
		srst_in |=> pullup_en_out == 3'h7 && pin_oe_out == 3'h0)
		else $error("pullups off during reset");
	AST_PULL_INPUT: assert property (@(posedge clk_in) disable iff (srst_in)
		pullup_en_out == ~pin_oe_out)
		else $error("pullup disagrees with direction");
	COV_PWR: cover property (@(posedge clk_in) pin_oe_out[1] && power_override_select_in);
endmodule

// >>> design/bpfs_tap.sv
/*
 Test access port controller with a two-bit instruction register.
 Assumes test pins are synchronous to clk_in and much slower than it.
*/
`timescale 1ns/10ps
module bpfs_tap (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic tck_in,
	input wire logic tms_in,
	input wire logic tdi_in,
	input wire logic trst_n_in,
	input wire logic [bpfs_pkg::BPFS_SCAN_W-1:0] scan_in,
	output logic tdo_out
);
	import bpfs_pkg::*;
	bpfs_tap_e st_q, st_d;
	logic tck_q, tdo_q, tdo_d, rise, fall;
	logic [BPFS_IR_W-1:0] ir_q, ir_d, irs_q, irs_d;
	logic [BPFS_SCAN_W-1:0] dr_q, dr_d;
	function automatic bpfs_tap_e next_st(input bpfs_tap_e s, input logic m);
		case (s)
			BPFS_TLR: return m ? BPFS_TLR : BPFS_IDLE;
			BPFS_IDLE: return m ? BPFS_SEL_DR : BPFS_IDLE;
			BPFS_SEL_DR: return m ? BPFS_SEL_IR : BPFS_CAP_DR;
			BPFS_CAP_DR: return m ? BPFS_EX1_DR : BPFS_SH_DR;
			BPFS_SH_DR: return m ? BPFS_EX1_DR : BPFS_SH_DR;
			BPFS_EX1_DR: return m ? BPFS_UPD_DR : BPFS_PA_DR;
			BPFS_PA_DR: return m ? BPFS_EX2_DR : BPFS_PA_DR;
			BPFS_EX2_DR: return m ? BPFS_UPD_DR : BPFS_SH_DR;
			BPFS_SEL_IR: return m ? BPFS_TLR : BPFS_CAP_IR;
			BPFS_CAP_IR: return m ? BPFS_EX1_IR : BPFS_SH_IR;
			BPFS_SH_IR: return m ? BPFS_EX1_IR : BPFS_SH_IR;
			BPFS_EX1_IR: return m ? BPFS_UPD_IR : BPFS_PA_IR;
			BPFS_PA_IR: return m ? BPFS_EX2_IR : BPFS_PA_IR;
			BPFS_EX2_IR: return m ? BPFS_UPD_IR : BPFS_SH_IR;
			default: return m ? BPFS_SEL_DR : BPFS_IDLE;
		endcase
	endfunction
	assign rise = tck_in && !tck_q;
	assign fall = !tck_in && tck_q;
	always_comb
	begin
		st_d = st_q;
		ir_d = ir_q;
		irs_d = irs_q;
		dr_d = dr_q;
		tdo_d = tdo_q;
		if (!trst_n_in)
		begin
			// Acts without waiting for any test clock edge
			st_d = BPFS_TLR;
			ir_d = BPFS_IR_BYPASS;
		end
		else if (rise)
		begin
			st_d = next_st(st_q, tms_in);
			case (st_q)
				BPFS_TLR: ir_d = BPFS_IR_BYPASS;
				BPFS_CAP_IR: irs_d = BPFS_IR_SCAN;
				BPFS_SH_IR: irs_d = {tdi_in, irs_q[BPFS_IR_W-1:1]};
				BPFS_UPD_IR: ir_d = irs_q;
				BPFS_CAP_DR: dr_d = (ir_q == BPFS_IR_SCAN) ? scan_in : '0;
				BPFS_SH_DR:
				begin
					if (ir_q == BPFS_IR_SCAN)
					begin
						dr_d = {tdi_in, dr_q[BPFS_SCAN_W-1:1]};
					end
					else
					begin
						dr_d[0] = tdi_in;
					end
				end
				default: dr_d = dr_q;
			endcase
		end
		else if (fall)
		begin
			// Output changes on the falling test clock edge
			if (st_q == BPFS_SH_IR)
			begin
				tdo_d = irs_q[0];
			end
			else if (st_q == BPFS_SH_DR)
			begin
				tdo_d = dr_q[0];
			end
		end
	end
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			st_q <= BPFS_TLR;
			ir_q <= BPFS_IR_BYPASS;
			irs_q <= '0;
			dr_q <= '0;
			tdo_q <= 1'b0;
			tck_q <= 1'b0;
		end
		else if (ce_in)
		begin
			st_q <= st_d;
			ir_q <= ir_d;
			irs_q <= irs_d;
			dr_q <= dr_d;
			tdo_q <= tdo_d;
			tck_q <= tck_in;
		end
	end
	assign tdo_out = tdo_q;
	AST_TAP_TRST: assert property (@(posedge clk_in) disable iff (srst_in)
		ce_in && !trst_n_in |=> st_q == BPFS_TLR && ir_q == BPFS_IR_BYPASS)
		else $error("test reset did not initialise controller");
	AST_TAP_STEP: assert property (@(posedge clk_in) disable iff (srst_in)
		ce_in && trst_n_in && !rise |=> st_q == $past(st_q))
		else $error("controller moved without test clock");
	AST_TAP_IDLE: assert property (@(posedge clk_in) disable iff (srst_in)
		ce_in && trst_n_in && rise && st_q == BPFS_TLR && !tms_in |=> st_q == BPFS_IDLE)
		else $error("controller missed idle");
	COV_SHIFT: cover property (@(posedge clk_in) st_q == BPFS_SH_DR && ir_q == BPFS_IR_SCAN);
endmodule

// >>> dv/bpfs_far_model.sv
/*
 Far-side model: secondary bus masters and an optional external arbiter.
 Assumes the bench says which arbiter stands and drives the masters' requests.
*/
`timescale 1ns/10ps
module bpfs_far_model (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ext_mode_in,
	input wire logic [bpfs_pkg::BPFS_NREQ-1:0] master_req_in,
	input wire logic [1:0] gnt_delay_in,
	input wire logic [bpfs_pkg::BPFS_NREQ-1:0] grant_pins_in,
	output logic [bpfs_pkg::BPFS_NREQ-1:0] req_pins_out
);
	import bpfs_pkg::*;
	logic [1:0] wait_q;
	logic gnt_q;
	// ----------------------------------------
	// External arbiter
	// ----------------------------------------
	// Grant only after a programmable wait, dropped as soon as request goes
	always_ff @(posedge clk_in)
	begin
		if (srst_in || !ext_mode_in || grant_pins_in[0] !== 1'b1)
		begin
			wait_q <= 2'h0;
			gnt_q <= 1'b0;
		end
		else if (wait_q == gnt_delay_in)
			gnt_q <= 1'b1;
		else
			wait_q <= wait_q + 2'h1;
	end
	// Masters own the request pins, except the grant pin in external mode
	assign req_pins_out = ext_mode_in ? {master_req_in[5:1], gnt_q} : master_req_in;
endmodule

// >>> dv/bridge_pin_function_select_tb_top.sv
/*
 Bench for the pin-function select block: AXI4-Lite tasks, pin and test port scenarios.
 Assumes bpfs_far_model drives the request pins.
*/
`timescale 1ns/10ps
module bridge_pin_function_select_tb_top;
	import bpfs_pkg::*;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic ce_in = 1'b1;
	logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
	logic [31:0] s_axi_wdata_in = 32'h0;
	logic [3:0] s_axi_wstrb_in = 4'hf;
	logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
	logic s_axi_arvalid_in = 0, s_axi_rready_in = 0;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
	logic s_axi_rvalid_out;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
	logic [31:0] s_axi_rdata_out;
	logic external_arbiter_strap_in = 0, clock_run_strap_in = 0, bridge_req_in = 0;
	logic [5:0] req_pins_in, grant_pins_out, arb_req_out, arb_gnt_in = 6'h0, mreq = 6'h0;
	logic [1:0] gdly = 2'h0;
	logic bridge_gnt_out, external_arbiter_out, clock_run_enable_out, clock_run_in_out;
	logic [2:0] general_pin_in, general_pin_out, general_pin_oe_out, general_pin_pullup_out;
	logic [2:0] ext_en = 3'h0, ext_val = 3'h0;
	logic power_override_output_out, secondary_bus_reset_n_out, test_data_out;
	logic test_clock_in = 0, test_mode_in = 0, test_data_in = 0, test_reset_n_in = 1;
	logic tap_o;
	logic [7:0] scan;
	int failures = 0;
	int tests_run = 0;
	// Wire level: own driver first, then outside driver, else pullup
	assign general_pin_in = (general_pin_oe_out & general_pin_out)
		| (~general_pin_oe_out & ext_en & ext_val)
		| (~general_pin_oe_out & ~ext_en & general_pin_pullup_out);
	bpfs_top dut (
		.clk_in, .srst_in, .ce_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
		.s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
		.s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
		.s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
		.s_axi_rready_in, .external_arbiter_strap_in, .clock_run_strap_in, .req_pins_in,
		.grant_pins_out, .arb_req_out, .arb_gnt_in, .bridge_req_in, .bridge_gnt_out,
		.external_arbiter_out, .clock_run_enable_out, .clock_run_in_out, .general_pin_in,
		.general_pin_out, .general_pin_oe_out, .general_pin_pullup_out,
		.power_override_output_out, .secondary_bus_reset_n_out, .test_clock_in, .test_mode_in,
		.test_data_in, .test_reset_n_in, .test_data_out
	);
	bpfs_far_model far (
		.clk_in(clk_in), .srst_in(srst_in), .ext_mode_in(external_arbiter_strap_in),
		.master_req_in(mreq), .gnt_delay_in(gdly), .grant_pins_in(grant_pins_out),
		.req_pins_out(req_pins_in)
	);
	always #4 clk_in = ~clk_in;
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_rsp(input string nm, input logic [1:0] e, input logic [1:0] g);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic close_out;
		if (failures == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_in);
		@(negedge clk_in);
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		@(posedge clk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		while (!(aw_ok && w_ok))
		begin
			@(posedge clk_in);
			if (!aw_ok && s_axi_awready_out === 1'b1)
			begin
				aw_ok = 1'b1;
				s_axi_awvalid_in <= 1'b0;
			end
			if (!w_ok && s_axi_wready_out === 1'b1)
			begin
				w_ok = 1'b1;
				s_axi_wvalid_in <= 1'b0;
			end
		end
		do
			@(posedge clk_in);
		while (s_axi_bvalid_out !== 1'b1);
		s_axi_bready_in <= 1'b0;
		chk_rsp("bresp", er, s_axi_bresp_out);
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		do
			@(posedge clk_in);
		while (s_axi_arready_out !== 1'b1);
		s_axi_arvalid_in <= 1'b0;
		do
			@(posedge clk_in);
		while (s_axi_rvalid_out !== 1'b1);
		s_axi_rready_in <= 1'b0;
		chk("rdata", ed, s_axi_rdata_out);
		chk_rsp("rresp", er, s_axi_rresp_out);
	endtask
	task automatic do_reset(input logic ea, input logic cr);
		@(posedge clk_in);
		srst_in <= 1'b1;
		bridge_req_in <= 1'b0;
		external_arbiter_strap_in <= ea;
		clock_run_strap_in <= cr;
		wait_n(8);
		chk("pullup_rst", 32'h7, general_pin_pullup_out);
		chk("sec_rst_on", 32'h0, secondary_bus_reset_n_out);
		@(posedge clk_in);
		srst_in <= 1'b0;
		wait_n(2);
		chk("ext_arb", ea, external_arbiter_out);
		chk("crun_en", cr, clock_run_enable_out);
		chk("sec_rst_off", 32'h1, secondary_bus_reset_n_out);
	endtask
	// Test clock held well above the two-cycle detection minimum
	task automatic tck_step(input logic m, input logic d);
		@(posedge clk_in);
		test_mode_in <= m;
		test_data_in <= d;
		repeat (3) @(posedge clk_in);
		test_clock_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		test_clock_in <= 1'b0;
		wait_n(4);
		tap_o = test_data_out;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		do_reset(1'b0, 1'b0);
		@(posedge clk_in);
		mreq <= 6'h2b;
		arb_gnt_in <= 6'h14;
		bridge_req_in <= 1'b1;
		ext_en <= 3'h1;
		ext_val <= 3'h1;
		wait_n(2);
		chk("arb_req", 32'h2b, arb_req_out);
		chk("grant_pins", 32'h14, grant_pins_out);
		chk("bridge_gnt", 32'h0, bridge_gnt_out);
		chk("crun_in_off", 32'h0, clock_run_in_out);
		@(posedge clk_in);
		ce_in <= 1'b0;
		mreq <= 6'h15;
		wait_n(2);
		chk("ce_hold", 32'h2b, arb_req_out);
		@(posedge clk_in);
		ce_in <= 1'b1;
		wait_n(2);
		chk("arb_req_run", 32'h15, arb_req_out);
		@(posedge clk_in);
		ext_en <= 3'h0;
		axi_wr(BPFS_OFS_DOUT, 32'h3, BPFS_RESP_OKAY);
		for (int d = 0; d < 8; d++)
		begin
			axi_wr(BPFS_OFS_DIR, d, BPFS_RESP_OKAY);
			wait_n(2);
			chk("oe", d, general_pin_oe_out);
			chk("pullup", ~d & 3'h7, general_pin_pullup_out);
			axi_rd(BPFS_OFS_DIN, ((d & 3) | ~d) & 3'h7, BPFS_RESP_OKAY);
		end
		axi_wr(BPFS_OFS_DIR, 32'h5, BPFS_RESP_OKAY);
		for (int c = 0; c < 8; c++)
		begin
			axi_wr(BPFS_OFS_GCTL, c << 20, BPFS_RESP_OKAY);
			wait_n(2);
			chk("pwr_out", c == 1 || c == 3, power_override_output_out);
			chk("oe_pin1", c == 1 || c == 3, general_pin_oe_out[1]);
		end
		axi_wr(BPFS_OFS_GCTL, 32'h1, BPFS_RESP_OKAY);
		wait_n(2);
		chk("sec_rst_sw", 32'h0, secondary_bus_reset_n_out);
		axi_wr(8'h20, 32'hffff_ffff, BPFS_RESP_SLVERR);
		axi_rd(8'h20, 32'h0, BPFS_RESP_SLVERR);
		axi_rd(BPFS_OFS_DIR, 32'h5, BPFS_RESP_OKAY);
		axi_rd(BPFS_OFS_STAT, 32'h0, BPFS_RESP_OKAY);
		do_reset(1'b1, 1'b1);
		@(posedge clk_in);
		gdly <= 2'h2;
		bridge_req_in <= 1'b1;
		mreq <= 6'h3e;
		arb_gnt_in <= 6'h3f;
		wait_n(2);
		chk("ext_gnt_pins", 32'h1, grant_pins_out);
		chk("ext_gnt_early", 32'h0, bridge_gnt_out);
		wait_n(4);
		chk("ext_gnt", 32'h1, bridge_gnt_out);
		chk("ext_arb_req", 32'h3e, arb_req_out);
		@(posedge clk_in);
		bridge_req_in <= 1'b0;
		wait_n(4);
		chk("ext_gnt_drop", 32'h0, bridge_gnt_out);
		axi_wr(BPFS_OFS_DIR, 32'h7, BPFS_RESP_OKAY);
		@(posedge clk_in);
		ext_en <= 3'h1;
		ext_val <= 3'h1;
		wait_n(2);
		chk("crun_oe", 32'h6, general_pin_oe_out);
		chk("crun_in", 32'h1, clock_run_in_out);
		axi_rd(BPFS_OFS_STAT, 32'h7, BPFS_RESP_OKAY);
		tck_step(1'b0, 1'b0);
		tck_step(1'b1, 1'b0);
		tck_step(1'b1, 1'b0);
		@(posedge clk_in);
		test_reset_n_in <= 1'b0;
		wait_n(3);
		@(posedge clk_in);
		test_reset_n_in <= 1'b1;
		tck_step(1'b0, 1'b0);
		tck_step(1'b1, 1'b0);
		tck_step(1'b1, 1'b0);
		tck_step(1'b0, 1'b0);
		tck_step(1'b0, 1'b0);
		chk("ir_capture", 32'h1, tap_o);
		tck_step(1'b0, 1'b1);
		tck_step(1'b1, 1'b0);
		tck_step(1'b1, 1'b0);
		tck_step(1'b0, 1'b0);
		tck_step(1'b1, 1'b0);
		tck_step(1'b0, 1'b0);
		for (int k = 0; k < 8; k++)
		begin
			tck_step(1'b0, 1'b0);
			scan[k] = tap_o;
		end
		chk("scan", 32'h07, scan);
		close_out();
	end
	initial
	begin
		#200000;
		failures++;
		close_out();
	end
endmodule
